// >>> core/cpsd_regs.sv
// Content protection status mirror and debug control registers
//
// Function
// R1: Session value bytes six, seven read-only
// R2: Bit 6 repeater, valid after key ready
// R3: Bit 5 set when key list ready
// R4: Bit 1 reports enhanced receiver features
// R5: Bit 0 reports unencrypted video during reauth
// R6: Bit 7 flags too many downstream devices
// R7: Bits 6:0 device count, zero if plain
// R8: Bit 3 flags more than seven levels
// R9: Bits 2:0 report cascade depth
// R10: Each key port read returns next byte
// R11: Debug bit 3 sends per-line channel checksums
// R12: Quick verify: short 2, long 16 frames
// R13: Normal verify: short 16, long 128 frames
// R14: Debug bit 1 accelerates authentication timers
// R15: Debug bit 0 selects fast remote master
// R16: Master speed mirrored in indirect status
// R17: Reserved bits read zero, ignore writes
//
// Chosen here: the Wishbone interface to the registers.
`include "cpsd_defs.svh"

module cpsd_regs #(
  parameter int KEY_LIST_DEPTH = 16,
  parameter int TICK_CYCLES = `CPSD_TICK_CYCLES,
  parameter int SPEEDUP_DIV = `CPSD_SPEEDUP_DIV
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire cpsd_pkg::cpsd_wb_req_t wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic [15:0] sessionHigh,
  input wire cpsd_pkg::cpsd_remote_t remote,
  input wire logic [7:0] keyInData,
  input wire logic keyInValid,
  output logic keyInReady,
  input wire cpsd_pkg::cpsd_video_t video,
  input wire logic frameStart,
  output logic [23:0] lineChecksum,
  output logic lineChecksumValid,
  output logic lineChecksumEnable,
  output logic quickLinkVerify,
  output logic shortLinkCheck,
  output logic longLinkCheck,
  output logic timerAccelerate,
  output logic authTick,
  output logic remoteMasterSpeed,
  output logic indirectStatusSpeed
);
  import cpsd_pkg::*;

  localparam logic [15:0] TICK_NORMAL = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] TICK_FAST = 16'((TICK_CYCLES / SPEEDUP_DIV > 0) ? TICK_CYCLES / SPEEDUP_DIV - 1 : 0);
  localparam logic [6:0] KEY_DEPTH = 7'(KEY_LIST_DEPTH);

  cpsd_state_t state;
  cpsd_state_t next_state;

  logic access;
  logic [7:0] index;
  logic [7:0] capsByte;
  logic [7:0] topoLow;
  logic [7:0] topoHigh;
  logic [7:0] readByte;
  logic popKey;
  logic [6:0] shortPeriod;
  logic [7:0] longPeriod;
  logic [7:0] frameNext;
  logic [23:0] accNext;

  // ------------------------------------------------------------
  // Status byte assembly
  // ------------------------------------------------------------
  always_comb begin
    capsByte = 8'h00; // R17
    // Repeater bit is meaningless until the key vector is ready
    capsByte[`CPSD_CAPS_REPEATER] = remote.repeater & remote.keyVectorReady; // R2
    capsByte[`CPSD_CAPS_LIST_READY] = remote.listReady; // R3
    capsByte[`CPSD_CAPS_FEATURES] = remote.features; // R4
    capsByte[`CPSD_CAPS_FAST_REAUTH] = remote.unencryptedDuringReauth; // R5

    topoLow = 8'h00;
    topoLow[`CPSD_TOPO_MAX_DEV] = remote.maxDevicesFlag | (remote.deviceCount > KEY_DEPTH); // R6
    if (remote.repeater) begin
      topoLow[6:0] = remote.deviceCount; // R7
    end

    topoHigh = 8'h00; // R17
    topoHigh[`CPSD_TOPO_MAX_CASCADE] = remote.cascadeLevels > `CPSD_MAX_CASCADE_LEVELS; // R8
    topoHigh[2:0] = remote.cascadeLevels[2:0]; // R9
  end

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign access = wbReq.cyc & wbReq.stb & ~state.ack;
  assign index = wbReq.adr[9:2];

  always_comb begin
    case (index)
      `CPSD_IDX_SESSION6: readByte = sessionHigh[7:0]; // R1
      `CPSD_IDX_SESSION7: readByte = sessionHigh[15:8]; // R1
      `CPSD_IDX_CAPS: readByte = capsByte;
      `CPSD_IDX_TOPO_LOW: readByte = topoLow;
      `CPSD_IDX_TOPO_HIGH: readByte = topoHigh;
      `CPSD_IDX_KEY_PORT: readByte = state.keyFull ? state.keyByte : 8'h00; // R10
      `CPSD_IDX_DEBUG: readByte = {4'h0, state.debug}; // R17
      `CPSD_IDX_INDIRECT: readByte = {7'h00, state.debug[`CPSD_DBG_MASTER_FAST]}; // R16
      default: readByte = 8'h00;
    endcase
  end

  // Only a read pops; a write to the port is ignored
  assign popKey = access & ~wbReq.we & (index == `CPSD_IDX_KEY_PORT); // R10

  // ------------------------------------------------------------
  // Link check periods
  // ------------------------------------------------------------
  always_comb begin
    if (state.debug[`CPSD_DBG_QUICK_LV]) begin
      shortPeriod = `CPSD_SHORT_QUICK; // R12
      longPeriod = {1'b0, `CPSD_LONG_QUICK}; // R12
    end else begin
      shortPeriod = `CPSD_SHORT_NORMAL; // R13
      longPeriod = `CPSD_LONG_NORMAL; // R13
    end
    frameNext = {1'b0, state.frameCnt} + 8'h01;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.ack = access;
    next_state.rdData = access ? {24'h000000, readByte} : 32'h00000000;

    if (access && wbReq.we && wbReq.sel[0] && index == `CPSD_IDX_DEBUG) begin
      next_state.debug = wbReq.dat[3:0] & `CPSD_DBG_WRITE_MASK; // R17
    end

    // Single holding byte: new data beats the pop in the same cycle
    if (popKey) begin
      next_state.keyFull = 1'b0;
    end
    if (keyInValid && state.keyReady) begin
      next_state.keyByte = keyInData;
      next_state.keyFull = 1'b1;
    end
    next_state.keyReady = ~next_state.keyFull;

    next_state.shortDue = 1'b0;
    next_state.longDue = 1'b0;
    if (frameStart) begin
      // Counter wraps at the long period; short period divides it
      if (frameNext >= longPeriod) begin
        next_state.frameCnt = 7'h00;
      end else begin
        next_state.frameCnt = frameNext[6:0];
      end
      next_state.shortDue = (state.frameCnt & (shortPeriod - 7'h01)) == 7'h00; // R12 R13
      next_state.longDue = state.frameCnt == 7'h00; // R12 R13
    end

    next_state.sumValid = 1'b0;
    if (video.lineEnd) begin
      next_state.acc = 24'h000000;
      if (state.debug[`CPSD_DBG_CHECKSUM]) begin
        next_state.sumOut = ~state.acc; // R11
        next_state.sumValid = 1'b1; // R11
      end
    end else if (video.pixelValid) begin
      next_state.acc = accNext;
    end

    next_state.authTick = 1'b0;
    if (state.tickCnt == 16'h0000) begin
      next_state.authTick = 1'b1;
      next_state.tickCnt = state.debug[`CPSD_DBG_TIMER_ACC] ? TICK_FAST : TICK_NORMAL; // R14
    end else if (state.debug[`CPSD_DBG_TIMER_ACC] && state.tickCnt > TICK_FAST) begin
      next_state.tickCnt = TICK_FAST; // R14
    end else begin
      next_state.tickCnt = state.tickCnt - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Ones-complement accumulation per colour channel
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : gChan
      logic [8:0] raw;
      assign raw = {1'b0, state.acc[ch*8 +: 8]} + {1'b0, video.rgb[ch*8 +: 8]};
      // End-around carry keeps the sum in ones-complement form
      assign accNext[ch*8 +: 8] = raw[7:0] + {7'h00, raw[8]}; // R11
    end
  endgenerate

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
      state.debug <= `CPSD_DBG_RESET;
      state.keyReady <= 1'b1;
      state.tickCnt <= TICK_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wbDatO = state.rdData;
  assign wbAck = state.ack;
  assign keyInReady = state.keyReady;
  assign lineChecksum = state.sumOut;
  assign lineChecksumValid = state.sumValid;
  assign lineChecksumEnable = state.debug[`CPSD_DBG_CHECKSUM]; // R11
  assign quickLinkVerify = state.debug[`CPSD_DBG_QUICK_LV];
  assign shortLinkCheck = state.shortDue;
  assign longLinkCheck = state.longDue;
  assign timerAccelerate = state.debug[`CPSD_DBG_TIMER_ACC]; // R14
  assign authTick = state.authTick;
  assign remoteMasterSpeed = state.debug[`CPSD_DBG_MASTER_FAST]; // R15
  assign indirectStatusSpeed = state.debug[`CPSD_DBG_MASTER_FAST]; // R16

endmodule // cpsd_regs

// >>> dv/cpsd_regs_bench.sv
// Self-checking bench for the status and debug register block
module cpsd_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cpsd_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic frameStart = 1'b0;
  logic [15:0] sessionHigh = 16'h0000;
  cpsd_wb_req_t wbReq = '0;
  cpsd_remote_t caps = '0;
  cpsd_remote_t remote;
  cpsd_video_t video = '0;
  logic [31:0] wbDatO, rd;
  logic [23:0] lineChecksum;
  logic [7:0] keyInData;
  logic wbAck, keyInValid, keyInReady, lineChecksumValid, lineChecksumEnable, quickLinkVerify;
  logic shortLinkCheck, longLinkCheck, timerAccelerate, authTick, remoteMasterSpeed, indirectStatusSpeed;
  int badCount = 0, compares = 0, cyc = 0, nShort = 0, nLong = 0, nTick = 0;
  logic [7:0] idx [9] = '{8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hC0, 8'hC8, 8'h10};
  cpsd_regs #(.TICK_CYCLES(16)) i_cpsd_regs (.clk, .reset_n, .wbReq, .wbDatO, .wbAck, .sessionHigh,
    .remote, .keyInData, .keyInValid, .keyInReady, .video, .frameStart, .lineChecksum, .lineChecksumValid,
    .lineChecksumEnable, .quickLinkVerify, .shortLinkCheck, .longLinkCheck, .timerAccelerate, .authTick,
    .remoteMasterSpeed, .indirectStatusSpeed);
  cpsd_remote_model i_cpsd_remote_model (.clk, .reset_n, .start, .caps, .keyInReady, .keyInData,
    .keyInValid, .remote);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    nShort <= nShort + shortLinkCheck;
    nLong <= nLong + longLinkCheck;
    nTick <= nTick + authTick;
    cyc <= cyc + 1;
    if (cyc > 8000) begin
      badCount++;
      stopTest();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] i, input logic [31:0] d);
    wbReq <= '{1'b1, 1'b1, w, s, {i, 2'b00}, d};
    do @(posedge clk); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [31:0] e);
    wb(1'b0, 4'hF, i, 32'h0);
    check(rd, e);
  endtask
  task automatic tRegs();
    foreach (idx[k]) rdchk(idx[k], 32'h0);
    sessionHigh <= 16'hC35A;
    wb(1'b1, 4'hF, 8'h9E, 32'hFF);
    rdchk(8'h9E, 32'h5A);
    rdchk(8'h9F, 32'hC3);
  endtask
  task automatic tDebug();
    wb(1'b1, 4'hF, 8'hC0, 32'hFF);
    rdchk(8'hC0, 32'h0F);
    rdchk(8'hC8, 32'h01);
    wb(1'b1, 4'hE, 8'hC0, 32'h0);
    check({lineChecksumEnable, quickLinkVerify, timerAccelerate, remoteMasterSpeed}, 32'hF);
    wb(1'b1, 4'h1, 8'hC0, 32'h0);
    rdchk(8'hC8, 32'h00);
  endtask
  task automatic tKeys();
    caps <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h14, 4'h9};
    start <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      do @(posedge clk); while (keyInReady !== 1'b0);
      rdchk(8'hA3, 32'h5A + k);
    end
    rdchk(8'hA3, 32'h0);
    rdchk(8'hA0, 32'h63);
    rdchk(8'hA1, 32'h94);
    rdchk(8'hA2, 32'h09);
    caps <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 7'h03, 4'h7};
    rdchk(8'hA0, 32'h23);
    rdchk(8'hA1, 32'h00);
    rdchk(8'hA2, 32'h07);
  endtask
  task automatic tFrames(input logic q, input int n, input int es, input int el);
    int s0, l0;
    wb(1'b1, 4'hF, 8'hC0, {29'h0, q, 2'b00});
    s0 = nShort;
    l0 = nLong;
    repeat (n) begin
      frameStart <= 1'b1;
      @(posedge clk);
      frameStart <= 1'b0;
      repeat (2) @(posedge clk);
    end
    check(nShort - s0, es);
    check(nLong - l0, el);
  endtask
  task automatic tSum(input logic en);
    wb(1'b1, 4'hF, 8'hC0, {28'h0, en, 3'b000});
    video <= '{1'b1, 1'b0, 24'h010203};
    @(posedge clk);
    video <= '{1'b1, 1'b0, 24'h100F0E};
    @(posedge clk);
    video <= '{1'b0, 1'b1, 24'h0};
    @(posedge clk);
    video <= '0;
    @(posedge clk);
    check(lineChecksumValid, en);
    if (en) check(lineChecksum, 32'hEEEEEE);
  endtask
  task automatic tTick(input logic f, input int e);
    int t0;
    wb(1'b1, 4'hF, 8'hC0, {30'h0, f, 1'b0});
    // Settle past the rate switch before counting
    repeat (20) @(posedge clk);
    t0 = nTick;
    repeat (64) @(posedge clk);
    check(nTick - t0, e);
  endtask
  task automatic stopTest();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    tRegs();
    tDebug();
    tKeys();
    tFrames(1'b0, 128, 8, 1);
    tFrames(1'b1, 16, 8, 1);
    tSum(1'b1);
    tSum(1'b0);
    tTick(1'b0, 4);
    tTick(1'b1, 32);
    stopTest();
  end
endmodule // cpsd_regs_bench
bind cpsd_regs cpsd_regs_properties i_cpsd_regs_properties (.clk, .reset_n, .wbReq, .wbDatO, .wbAck, .remote,
  .keyInValid, .keyInReady, .frameStart, .lineChecksumEnable, .quickLinkVerify, .timerAccelerate,
  .remoteMasterSpeed, .indirectStatusSpeed, .shortLinkCheck, .longLinkCheck);

// >>> dv/cpsd_regs_properties.sv
// Port checks for the status and debug register block
module cpsd_regs_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire cpsd_pkg::cpsd_wb_req_t wbReq,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  input wire cpsd_pkg::cpsd_remote_t remote,
  input wire logic keyInValid,
  input wire logic keyInReady,
  input wire logic frameStart,
  input wire logic lineChecksumEnable,
  input wire logic quickLinkVerify,
  input wire logic timerAccelerate,
  input wire logic remoteMasterSpeed,
  input wire logic indirectStatusSpeed,
  input wire logic shortLinkCheck,
  input wire logic longLinkCheck
);
  import cpsd_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic taken;
  logic [7:0] caps;
  logic [7:0] topo;
  logic [3:0] dbg;
  assign taken = wbReq.cyc && wbReq.stb && !wbAck;
  assign caps = {1'b0, remote.repeater && remote.keyVectorReady, remote.listReady, 3'b000, remote.features,
    remote.unencryptedDuringReauth};
  assign topo = {4'h0, remote.cascadeLevels > 4'h7, remote.cascadeLevels[2:0]};
  assign dbg = wbReq.dat[3:0];
  property p_ack; taken |=> wbAck ##1 !wbAck; endproperty
  property p_hi; wbAck |-> wbDatO[31:8] == 24'h000000; endproperty
  property p_caps; taken && !wbReq.we && wbReq.adr == 10'h280 |=> wbDatO[7:0] == $past(caps); endproperty
  property p_topo; taken && !wbReq.we && wbReq.adr == 10'h288 |=> wbDatO[7:0] == $past(topo); endproperty
  property p_dbg; taken && wbReq.we && wbReq.sel[0] && wbReq.adr == 10'h300
    |=> {lineChecksumEnable, quickLinkVerify, timerAccelerate, remoteMasterSpeed} == $past(dbg); endproperty
  property p_key; keyInValid && keyInReady |=> !keyInReady; endproperty
  property p_pulse; shortLinkCheck || longLinkCheck |-> $past(frameStart); endproperty
  property p_nest; longLinkCheck |-> shortLinkCheck; endproperty
  property p_mir; remoteMasterSpeed == indirectStatusSpeed; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_caps: assert property (p_caps) else $error("capability read");
  a_topo: assert property (p_topo) else $error("cascade read");
  a_dbg: assert property (p_dbg) else $error("debug outputs");
  a_key: assert property (p_key) else $error("key holder");
  a_pulse: assert property (p_pulse) else $error("check without frame");
  a_nest: assert property (p_nest) else $error("long without short");
  a_mir: assert property (p_mir) else $error("speed mirror");
  c_rd: cover property (taken && !wbReq.we);
  c_long: cover property (longLinkCheck);
  c_key: cover property (keyInValid && keyInReady);
endmodule // cpsd_regs_properties

// >>> dv/cpsd_remote_model.sv
// Downstream receiver: capability status and key byte stream
module cpsd_remote_model #(
  parameter int NBYTES = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire cpsd_pkg::cpsd_remote_t caps,
  input wire logic keyInReady,
  output logic [7:0] keyInData,
  output logic keyInValid,
  output cpsd_pkg::cpsd_remote_t remote
);
  import cpsd_pkg::*;
  int sent;
  logic done;
  always_ff @(posedge clk) begin
    if (!reset_n || !start) begin
      sent <= 0;
      keyInValid <= 1'b0;
      keyInData <= 8'h00;
      done <= 1'b0;
    end else if (keyInValid && keyInReady) begin
      // Idle data inverts so a stale byte never looks valid
      keyInValid <= 1'b0;
      keyInData <= ~keyInData;
      sent <= sent + 1;
      done <= (sent + 1 == NBYTES);
    end else if (!keyInValid && sent < NBYTES) begin
      keyInValid <= 1'b1;
      keyInData <= 8'h5A + 8'(sent);
    end
  end
  always_comb begin
    remote = caps;
    remote.keyVectorReady = start;
    remote.listReady = done;
  end
endmodule // cpsd_remote_model

// >>> inc/cpsd_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CPSD_DEFS_SVH
`define CPSD_DEFS_SVH

// Register indexes; byte address is four times the index
`define CPSD_IDX_SESSION6 8'h9E
`define CPSD_IDX_SESSION7 8'h9F
`define CPSD_IDX_CAPS 8'hA0
`define CPSD_IDX_TOPO_LOW 8'hA1
`define CPSD_IDX_TOPO_HIGH 8'hA2
`define CPSD_IDX_KEY_PORT 8'hA3
`define CPSD_IDX_DEBUG 8'hC0
`define CPSD_IDX_INDIRECT 8'hC8

// Capability fields
`define CPSD_CAPS_REPEATER 6
`define CPSD_CAPS_LIST_READY 5
`define CPSD_CAPS_FEATURES 1
`define CPSD_CAPS_FAST_REAUTH 0

// Topology fields
`define CPSD_TOPO_MAX_DEV 7
`define CPSD_TOPO_MAX_CASCADE 3
`define CPSD_MAX_CASCADE_LEVELS 4'h7

// Debug control fields
`define CPSD_DBG_CHECKSUM 3
`define CPSD_DBG_QUICK_LV 2
`define CPSD_DBG_TIMER_ACC 1
`define CPSD_DBG_MASTER_FAST 0
`define CPSD_DBG_WRITE_MASK 4'hF
`define CPSD_DBG_RESET 4'h0

// Indirect status field
`define CPSD_IND_MASTER_FAST 0

// Link check periods in frames
`define CPSD_SHORT_QUICK 7'h02
`define CPSD_LONG_QUICK 7'h10
`define CPSD_SHORT_NORMAL 7'h10
`define CPSD_LONG_NORMAL 8'h80

// Authentication timer base tick
`define CPSD_CLK_PERIOD_NS 5
`define CPSD_TICK_NS 1000
`define CPSD_TICK_CYCLES (`CPSD_TICK_NS / `CPSD_CLK_PERIOD_NS)
`define CPSD_SPEEDUP_DIV 8

`endif

// >>> inc/cpsd_pkg.sv
// Types shared by the content protection status and debug registers
package cpsd_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } cpsd_wb_req_t;

  typedef struct packed {
    logic keyVectorReady;
    logic repeater;
    logic listReady;
    logic features;
    logic unencryptedDuringReauth;
    logic maxDevicesFlag;
    logic [6:0] deviceCount;
    logic [3:0] cascadeLevels;
  } cpsd_remote_t;

  typedef struct packed {
    logic pixelValid;
    logic lineEnd;
    logic [23:0] rgb;
  } cpsd_video_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdData;
    logic [3:0] debug;
    logic [7:0] keyByte;
    logic keyFull;
    logic keyReady;
    logic [6:0] frameCnt;
    logic shortDue;
    logic longDue;
    logic [23:0] acc;
    logic [23:0] sumOut;
    logic sumValid;
    logic [15:0] tickCnt;
    logic authTick;
  } cpsd_state_t;

endpackage
